//--- shared/cfub_regs.svh
// constants of the flag update and branch block
// Contract
// - decimal add sets carry when result exceeds 9999h word or 99h byte
// - decimal add sets zero on zero result; overflow left as it was
// - decrement writes destination minus one back as result
// - decrement: zero when destination was 1; carry clear only when it was 0
// - decrement: overflow only when destination was 08000h word or 080h byte
// - double decrement writes destination minus two back as result
// - double decrement: zero when destination was 2; carry clear for 0 or 1
// - double decrement: overflow for 08001h/08000h word or 081h/080h byte
// - interrupt disable clears only the global enable bit, mask 08h inverted
// - interrupt enable sets global enable bit by OR with 0008h only
// - after enabling, next instruction always runs before any interrupt is taken
// - disable may not guard the following instruction; software adds one spare
// - increment adds one; zero and carry set only from all-ones destination
// - increment: overflow only when destination was 07FFFh word or 07Fh byte
// - double increment adds two; zero from 0FFFEh, carry from 0FFFEh or 0FFFFh
// - double increment: overflow from 07FFEh or 07FFFh word, 07Eh or 07Fh byte
// - invert replaces destination by its bitwise complement within operand size
// - invert: carry is not zero; overflow when original operand was negative
// - negative flag follows the result's most significant bit
// - jump on carry set adds sign-extended doubled 10-bit offset to 20-bit counter
// - jump on carry clear lets the counter continue sequentially
// - only interrupt enable/disable touch the enable bit; none touches oscillator-off or processor-off; swWrite loads all bits, these included
`ifndef CFUB_REGS_SVH
`define CFUB_REGS_SVH
`define CFUB_C_BIT       0
`define CFUB_Z_BIT       1
`define CFUB_N_BIT       2
`define CFUB_IRQEN_BIT   3
`define CFUB_PROCOFF_BIT 4
`define CFUB_OSCSTOP_BIT 5
`define CFUB_V_BIT       8
`define CFUB_IRQEN_MASK  16'h0008
`define CFUB_SW_RESET    16'h0000
`define CFUB_ZERO        16'h0000
`define CFUB_ONE         16'h0001
`define CFUB_TWO         16'h0002
`define CFUB_WORD_MASK   16'hffff
`define CFUB_BYTE_MASK   16'h00ff
`define CFUB_WORD_SIGN   16'h8000
`define CFUB_BYTE_SIGN   16'h0080
`define CFUB_BCD_DIGITS  4
`define CFUB_BCD_MAX     5'h09
`define CFUB_BCD_ADJ     5'h06
`define CFUB_PC_RESET    20'h00000
`endif

//--- shared/cfub_pkg.sv
// types of the flag update and branch block
package cfub_pkg;
   typedef enum logic [3:0] {
      DECIMAL_ADD_OP,
      DECREMENT_OP,
      DOUBLE_DECREMENT_OP,
      INCREMENT_OP,
      DOUBLE_INCREMENT_OP,
      BITWISE_INVERT_OP,
      INTERRUPT_DISABLE_OP,
      INTERRUPT_ENABLE_OP,
      JUMP_ON_CARRY_OP
   } cfub_op_e;
   typedef struct packed {
      cfub_op_e    op;
      logic        byteMode;
      logic [15:0] dst;
      logic [15:0] src;
      logic [9:0]  offset;
   } cfub_req_s;
   typedef struct packed {
      logic v;
      logic n;
      logic z;
      logic c;
   } cfub_flags_s;
endpackage

//--- hw/cfub_core.sv
// flag update, result and jump-on-carry logic of the core
`include "cfub_regs.svh"
module cfub_core
   import cfub_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        reqValid,
   input  wire cfub_req_s   req,
   input  wire logic [19:0] pcCurrent,
   input  wire logic        swWrite,
   input  wire logic [15:0] swWriteData,
   input  wire logic        instrDone,
   input  wire logic        irqPending,
   output logic             irqAccept,
   output logic [15:0]      statusWord,
   output logic [15:0]      result,
   output logic             resultValid,
   output logic [19:0]      pcTarget,
   output logic             pcValid
);

   // ***********************************************************
   // reset release
   // ***********************************************************
   logic [1:0]  rstnSync;
   logic        rstnInt;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstnSync <= 2'h0;
      end else begin
         rstnSync <= {rstnSync[0], 1'h1};
      end
   end

   assign rstnInt = rstnSync[1];

   // ***********************************************************
   // decimal adder
   // ***********************************************************
   function automatic logic [16:0] bcdAdd(
      input logic [15:0] a,
      input logic [15:0] b,
      input logic        cin,
      input logic        isByte
   );
      logic [4:0]  s;
      logic        cy;
      logic        byteCy;
      logic [15:0] r;
      cy     = cin;
      byteCy = 1'h0;
      r      = `CFUB_ZERO;
      for (int i = 0; i < `CFUB_BCD_DIGITS; i++) begin
         s = {1'h0, a[4*i +: 4]} + {1'h0, b[4*i +: 4]} + {4'h0, cy};
         if (s > `CFUB_BCD_MAX) begin
            s  = s + `CFUB_BCD_ADJ;
            cy = 1'h1;
         end else begin
            cy = 1'h0;
         end
         r[4*i +: 4] = s[3:0];
         if (i == 1) begin
            byteCy = cy;
         end
      end
      return {(isByte ? byteCy : cy), r};
   endfunction

   // ***********************************************************
   // operand size
   // ***********************************************************
   logic [15:0] sizeMask;
   logic [15:0] sizeSign;
   logic [15:0] dstM;
   logic [15:0] srcM;
   logic [16:0] bcdSum;

   assign sizeMask = req.byteMode ? `CFUB_BYTE_MASK : `CFUB_WORD_MASK;
   assign sizeSign = req.byteMode ? `CFUB_BYTE_SIGN : `CFUB_WORD_SIGN;
   assign dstM     = req.dst & sizeMask;
   assign srcM     = req.src & sizeMask;
   assign bcdSum   = bcdAdd(dstM, srcM, statusWord[`CFUB_C_BIT], req.byteMode);

   // ***********************************************************
   // result and flags
   // ***********************************************************
   logic [15:0] next_result;
   cfub_flags_s next_flags;
   logic        arith;

   always_comb begin
      next_result  = `CFUB_ZERO;
      next_flags.c = statusWord[`CFUB_C_BIT];
      next_flags.z = statusWord[`CFUB_Z_BIT];
      next_flags.n = statusWord[`CFUB_N_BIT];
      next_flags.v = statusWord[`CFUB_V_BIT];
      arith        = 1'h1;
      case (req.op)
         DECIMAL_ADD_OP: begin
            next_result  = bcdSum[15:0] & sizeMask;
            next_flags.c = bcdSum[16];
            next_flags.z = (next_result == `CFUB_ZERO);
         end
         DECREMENT_OP: begin
            next_result  = (dstM - `CFUB_ONE) & sizeMask;
            next_flags.z = (dstM == `CFUB_ONE);
            next_flags.c = (dstM != `CFUB_ZERO);
            next_flags.v = (dstM == sizeSign);
         end
         DOUBLE_DECREMENT_OP: begin
            next_result  = (dstM - `CFUB_TWO) & sizeMask;
            next_flags.z = (dstM == `CFUB_TWO);
            next_flags.c = (dstM >= `CFUB_TWO);
            next_flags.v = (dstM == sizeSign) ||
                           (dstM == sizeSign + `CFUB_ONE);
         end
         INCREMENT_OP: begin
            next_result  = (dstM + `CFUB_ONE) & sizeMask;
            next_flags.z = (dstM == sizeMask);
            next_flags.c = (dstM == sizeMask);
            next_flags.v = (dstM == sizeSign - `CFUB_ONE);
         end
         DOUBLE_INCREMENT_OP: begin
            next_result  = (dstM + `CFUB_TWO) & sizeMask;
            next_flags.z = (dstM == sizeMask - `CFUB_ONE);
            next_flags.c = (dstM >= sizeMask - `CFUB_ONE);
            next_flags.v = (dstM == sizeSign - `CFUB_ONE) ||
                           (dstM == sizeSign - `CFUB_TWO);
         end
         BITWISE_INVERT_OP: begin
            next_result  = ~dstM & sizeMask;
            next_flags.z = (next_result == `CFUB_ZERO);
            next_flags.c = (next_result != `CFUB_ZERO);
            next_flags.v = ((dstM & sizeSign) != `CFUB_ZERO);
         end
         default: begin
            arith = 1'h0;
         end
      endcase
      if (arith) begin
         next_flags.n = ((next_result & sizeSign) != `CFUB_ZERO);
      end
   end

   // ***********************************************************
   // status word
   // ***********************************************************
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         statusWord <= `CFUB_SW_RESET;
      end else if (reqValid) begin
         case (req.op)
            INTERRUPT_DISABLE_OP: begin
               statusWord <= statusWord & ~`CFUB_IRQEN_MASK;
            end
            INTERRUPT_ENABLE_OP: begin
               statusWord <= statusWord | `CFUB_IRQEN_MASK;
            end
            JUMP_ON_CARRY_OP: begin
               statusWord <= statusWord;
            end
            default: begin
               // only the four arithmetic flags move
               statusWord[`CFUB_C_BIT] <= next_flags.c;
               statusWord[`CFUB_Z_BIT] <= next_flags.z;
               statusWord[`CFUB_N_BIT] <= next_flags.n;
               statusWord[`CFUB_V_BIT] <= next_flags.v;
            end
         endcase
      end else if (swWrite) begin
         statusWord <= swWriteData;
      end
   end

   // ***********************************************************
   // result output
   // ***********************************************************
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         result      <= `CFUB_ZERO;
         resultValid <= 1'h0;
      end else begin
         resultValid <= reqValid && arith;
         if (reqValid && arith) begin
            result <= next_result;
         end
      end
   end

   // ***********************************************************
   // jump on carry
   // ***********************************************************
   logic [19:0] jumpOffset;
   logic [19:0] next_pc;

   assign jumpOffset = {{9{req.offset[9]}}, req.offset, 1'h0};
   assign next_pc    = statusWord[`CFUB_C_BIT] ?
                       pcCurrent + jumpOffset :
                       pcCurrent;

   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         pcTarget <= `CFUB_PC_RESET;
         pcValid  <= 1'h0;
      end else begin
         pcValid <= reqValid && (req.op == JUMP_ON_CARRY_OP);
         if (reqValid && (req.op == JUMP_ON_CARRY_OP)) begin
            pcTarget <= next_pc;
         end
      end
   end

   // ***********************************************************
   // interrupt gating
   // ***********************************************************
   logic enableHold;

   // set wins over the clear by the enabling instruction's own completion
   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         enableHold <= 1'h0;
      end else if (reqValid && (req.op == INTERRUPT_ENABLE_OP)) begin
         enableHold <= 1'h1;
      end else if (instrDone) begin
         enableHold <= 1'h0;
      end
   end

   // registered enable: a disable acts one cycle late, guarding nothing in between
   assign irqAccept = irqPending && statusWord[`CFUB_IRQEN_BIT] && !enableHold;

   // ***********************************************************
   // checks
   // ***********************************************************
   a_bcd_zero_flag:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DECIMAL_ADD_OP |=>
      statusWord[`CFUB_Z_BIT] == (result == `CFUB_ZERO))
      else $error("decimal add zero flag wrong");

   a_bcd_no_carry:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DECIMAL_ADD_OP && srcM == `CFUB_ZERO &&
      !statusWord[`CFUB_C_BIT] |=> !statusWord[`CFUB_C_BIT] && result == $past(dstM))
      else $error("decimal add of zero changed value or carry");

   a_decrement_flags:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DECREMENT_OP |=>
      statusWord[`CFUB_Z_BIT] == ($past(dstM) == `CFUB_ONE) &&
      statusWord[`CFUB_C_BIT] == ($past(dstM) != `CFUB_ZERO) &&
      result == (($past(dstM) - `CFUB_ONE) & $past(sizeMask)))
      else $error("decrement flags or result wrong");

   a_decrement_overflow:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DECREMENT_OP |=>
      statusWord[`CFUB_V_BIT] == ($past(dstM) == $past(sizeSign)))
      else $error("decrement overflow wrong");

   a_decr_two_flags:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DOUBLE_DECREMENT_OP |=>
      statusWord[`CFUB_Z_BIT] == ($past(dstM) == `CFUB_TWO) &&
      statusWord[`CFUB_C_BIT] == ($past(dstM) > `CFUB_ONE))
      else $error("double decrement flags wrong");

   a_inc_wrap:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == INCREMENT_OP && dstM == sizeMask |=>
      statusWord[`CFUB_Z_BIT] && statusWord[`CFUB_C_BIT] && result == `CFUB_ZERO)
      else $error("increment wrap flags wrong");

   a_incr_two_overflow:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DOUBLE_INCREMENT_OP |=>
      statusWord[`CFUB_V_BIT] == ($past(dstM) == $past(sizeSign) - `CFUB_ONE ||
                                  $past(dstM) == $past(sizeSign) - `CFUB_TWO))
      else $error("double increment overflow wrong");

   a_invert_carry:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == BITWISE_INVERT_OP |=>
      statusWord[`CFUB_C_BIT] == !statusWord[`CFUB_Z_BIT] &&
      result == (~$past(dstM) & $past(sizeMask)))
      else $error("invert carry or result wrong");

   a_mode_bits_kept:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op != INTERRUPT_DISABLE_OP && req.op != INTERRUPT_ENABLE_OP |=>
      $stable(statusWord[`CFUB_OSCSTOP_BIT:`CFUB_IRQEN_BIT]))
      else $error("mode bits changed");

   a_enable_clear_only:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == INTERRUPT_DISABLE_OP |=>
      statusWord == ($past(statusWord) & ~`CFUB_IRQEN_MASK))
      else $error("interrupt disable touched other bits");

   a_enable_delay:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == INTERRUPT_ENABLE_OP |=> !irqAccept)
      else $error("interrupt taken right after enable");

   a_jump_target:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == JUMP_ON_CARRY_OP |=> pcValid &&
      pcTarget == ($past(statusWord[`CFUB_C_BIT]) ?
                   $past(pcCurrent) + $past(jumpOffset) : $past(pcCurrent)))
      else $error("jump target wrong");

   a_incr_overflow:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == INCREMENT_OP |=>
      statusWord[`CFUB_V_BIT] == ($past(dstM) == $past(sizeSign) - `CFUB_ONE))
      else $error("increment overflow wrong");

   a_incr_two_flags:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DOUBLE_INCREMENT_OP |=>
      statusWord[`CFUB_Z_BIT] == ($past(dstM) == $past(sizeMask) - `CFUB_ONE) &&
      statusWord[`CFUB_C_BIT] == ($past(dstM) >= $past(sizeMask) - `CFUB_ONE) &&
      result == (($past(dstM) + `CFUB_TWO) & $past(sizeMask)))
      else $error("double increment flags or result wrong");

   a_decr_two_result:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == DOUBLE_DECREMENT_OP |=>
      result == (($past(dstM) - `CFUB_TWO) & $past(sizeMask)) &&
      statusWord[`CFUB_V_BIT] == ($past(dstM) == $past(sizeSign) ||
                                  $past(dstM) == $past(sizeSign) + `CFUB_ONE))
      else $error("double decrement result or overflow wrong");

   a_enable_set_only:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == INTERRUPT_ENABLE_OP |=>
      statusWord == ($past(statusWord) | `CFUB_IRQEN_MASK))
      else $error("interrupt enable touched other bits");

   a_negative_msb:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && arith |=>
      resultValid && statusWord[`CFUB_N_BIT] == ((result & $past(sizeSign)) != `CFUB_ZERO))
      else $error("negative flag does not follow result sign");

   a_byte_upper_clear:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && arith && req.byteMode |=>
      (result & ~`CFUB_BYTE_MASK) == `CFUB_ZERO)
      else $error("byte result has upper bits set");

   a_jump_not_taken:
   assert property (@(posedge clk) disable iff (!rstnInt)
      reqValid && req.op == JUMP_ON_CARRY_OP && !statusWord[`CFUB_C_BIT] |=>
      pcValid && pcTarget == $past(pcCurrent) && !resultValid)
      else $error("jump without carry moved the counter");

endmodule // cfub_core

//--- tb/test_cpu_flag_update_and_branch.sv
// self-checking testbench of the flag update and branch block
module test_cpu_flag_update_and_branch import cfub_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        reqValid = 1'b0;
   cfub_req_s   req = '0;
   logic [19:0] pcCurrent = 20'h00000;
   logic        swWrite = 1'b0;
   logic [15:0] swWriteData = 16'h0000;
   logic        instrDone = 1'b0;
   logic        irqPending = 1'b0;
   logic        irqAccept, resultValid, pcValid;
   logic [15:0] statusWord, result;
   logic [19:0] pcTarget;
   logic [15:0] sw;
   logic [31:0] rnd;
   int          errTotal = 0;
   int          cmpCount = 0;
   int          seed = 81;
   cfub_op_e    ops [6] = '{DECIMAL_ADD_OP, DECREMENT_OP, DOUBLE_DECREMENT_OP,
                            INCREMENT_OP, DOUBLE_INCREMENT_OP, BITWISE_INVERT_OP};

   always #25 clk = ~clk;

   cfub_core DUT (.clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
      .pcCurrent(pcCurrent), .swWrite(swWrite), .swWriteData(swWriteData),
      .instrDone(instrDone), .irqPending(irqPending), .irqAccept(irqAccept),
      .statusWord(statusWord), .result(result), .resultValid(resultValid),
      .pcTarget(pcTarget), .pcValid(pcValid));

   // ****************************************
   // helpers
   // ****************************************
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [19:0] expv, input logic [19:0] got);
      cmpCount++;
      if (got !== expv) begin
         errTotal++;
         $display("CHECK FAILED %s expected %h seen %h", name, expv, got);
      end
   endtask

   // expected result and status word of an arithmetic operation
   function automatic void model(input cfub_op_e op, input logic bm, input logic [15:0] d0,
      input logic [15:0] s0, input logic [15:0] swIn, output logic [15:0] r,
      output logic [15:0] swOut);
      logic [15:0] m, sg, d, s;
      logic        v, z, c;
      int          dig, cy;
      m = bm ? 16'h00ff : 16'hffff;
      sg = bm ? 16'h0080 : 16'h8000;
      d = d0 & m;
      s = s0 & m;
      v = swIn[8];
      r = 16'h0000;
      case (op)
         DECREMENT_OP: begin
            r = (d - 16'h0001) & m;
            z = d == 16'h0001;
            c = d != 16'h0000;
            v = d == sg;
         end
         DOUBLE_DECREMENT_OP: begin
            r = (d - 16'h0002) & m;
            z = d == 16'h0002;
            c = d > 16'h0001;
            v = (d == sg) || (d == sg + 16'h0001);
         end
         INCREMENT_OP: begin
            r = (d + 16'h0001) & m;
            z = d == m;
            c = z;
            v = d == sg - 16'h0001;
         end
         DOUBLE_INCREMENT_OP: begin
            r = (d + 16'h0002) & m;
            z = d == m - 16'h0001;
            c = d >= m - 16'h0001;
            v = (d == sg - 16'h0002) || (d == sg - 16'h0001);
         end
         BITWISE_INVERT_OP: begin
            r = ~d & m;
            z = r == 16'h0000;
            c = !z;
            v = (d & sg) != 16'h0000;
         end
         default: begin
            cy = swIn[0];
            for (int i = 0; i < (bm ? 2 : 4); i++) begin
               dig = d[4*i +: 4] + s[4*i +: 4] + cy;
               cy = dig > 9;
               if (cy != 0) dig -= 10;
               r[4*i +: 4] = dig[3:0];
            end
            c = cy != 0;
            z = r == 16'h0000;
         end
      endcase
      swOut = swIn;
      swOut[0] = c;
      swOut[1] = z;
      swOut[2] = (r & sg) != 16'h0000;
      swOut[8] = v;
   endfunction

   function automatic logic [15:0] rbcd();
      logic [15:0] r;
      for (int i = 0; i < 4; i++) r[4*i +: 4] = 4'($unsigned($random(seed)) % 10);
      return r;
   endfunction

   task automatic issue(input cfub_op_e op, input logic bm, input logic [15:0] d,
      input logic [15:0] s, input logic [9:0] off, input logic [19:0] pc);
      @(negedge clk); // idle edge between requests
      req.op = op;
      req.byteMode = bm;
      req.dst = d;
      req.src = s;
      req.offset = off;
      pcCurrent = pc;
      reqValid = 1'b1;
      @(negedge clk);
      reqValid = 1'b0;
   endtask

   task automatic arith(input cfub_op_e op, input logic bm, input logic [15:0] d,
      input logic [15:0] s);
      logic [15:0] r, nsw;
      model(op, bm, d, s, sw, r, nsw);
      issue(op, bm, d, s, 10'h000, 20'h00000);
      chk("resultValid", 20'h00001, {19'h0, resultValid});
      chk("result", {4'h0, r}, {4'h0, result});
      chk("statusWord", {4'h0, nsw}, {4'h0, statusWord});
      sw = nsw;
   endtask

   task automatic swLoad(input logic [15:0] d);
      swWriteData = d;
      swWrite = 1'b1;
      @(negedge clk);
      swWrite = 1'b0;
      sw = d;
      chk("statusWord", {4'h0, sw}, {4'h0, statusWord});
   endtask

   task automatic jump(input logic [9:0] off, input logic [19:0] pc);
      logic [19:0] t;
      t = sw[0] ? pc + {{9{off[9]}}, off, 1'b0} : pc;
      issue(JUMP_ON_CARRY_OP, 1'b0, 16'h0000, 16'h0000, off, pc);
      chk("pcValid", 20'h00001, {19'h0, pcValid});
      chk("pcTarget", t, pcTarget);
      chk("statusWord", {4'h0, sw}, {4'h0, statusWord});
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [15:0] m, sg, d;
      logic [15:0] cr [9];
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk("statusWord", 20'h00000, {4'h0, statusWord});
      swLoad(16'h0038);
      for (int bm = 0; bm < 2; bm++) begin
         m = bm ? 16'h00ff : 16'hffff;
         sg = bm ? 16'h0080 : 16'h8000;
         cr = '{16'h0000, 16'h0001, 16'h0002, sg - 16'h0002, sg - 16'h0001, sg,
                sg + 16'h0001, m - 16'h0001, m};
         for (int k = 0; k < 9; k++)
            for (int j = 1; j < 6; j++) arith(ops[j], bm[0], cr[k], 16'h0000);
         arith(DECIMAL_ADD_OP, bm[0], 16'h9999, 16'h0001);
         arith(DECIMAL_ADD_OP, bm[0], 16'h0000, 16'h0000);
      end
      for (int i = 0; i < 300; i++) begin
         rnd = $random(seed);
         d = rnd[31:16];
         if (rnd[2:0] == 3'h0) d = rbcd() & 16'hff00;
         if (rnd[3]) arith(DECIMAL_ADD_OP, rnd[4], rbcd(), rbcd());
         else arith(ops[1 + $unsigned(rnd[15:8]) % 5], rnd[4], d, 16'h0000);
      end
      irqPending = 1'b1;
      @(negedge clk);
      chk("irqAccept", 20'h00001, {19'h0, irqAccept});
      issue(INTERRUPT_DISABLE_OP, 1'b0, 16'h0000, 16'h0000, 10'h000, 20'h00000);
      sw = sw & 16'hfff7;
      chk("statusWord", {4'h0, sw}, {4'h0, statusWord});
      chk("irqAccept", 20'h00000, {19'h0, irqAccept});
      issue(INTERRUPT_ENABLE_OP, 1'b0, 16'h0000, 16'h0000, 10'h000, 20'h00000);
      sw = sw | 16'h0008;
      chk("statusWord", {4'h0, sw}, {4'h0, statusWord});
      chk("resultValid", 20'h00000, {19'h0, resultValid});
      chk("irqAccept", 20'h00000, {19'h0, irqAccept});
      repeat (3) @(negedge clk);
      chk("irqAccept", 20'h00000, {19'h0, irqAccept});
      instrDone = 1'b1;
      @(negedge clk);
      instrDone = 1'b0;
      chk("irqAccept", 20'h00001, {19'h0, irqAccept});
      @(negedge clk);
      instrDone = 1'b1;
      issue(INTERRUPT_ENABLE_OP, 1'b0, 16'h0000, 16'h0000, 10'h000, 20'h00000);
      instrDone = 1'b0;
      chk("irqAccept", 20'h00000, {19'h0, irqAccept});
      irqPending = 1'b0;
      for (int i = 0; i < 40; i++) begin
         rnd = $random(seed);
         swLoad({sw[15:1], rnd[0]});
         if (i < 2) jump(i ? 10'h200 : 10'h1ff, 20'hfffff);
         else jump(rnd[10:1], 20'($random(seed)));
      end
      results();
   end

   initial begin
      #200000;
      errTotal++;
      $display("watchdog expired");
      results();
   end
endmodule // test_cpu_flag_update_and_branch
